// [bench/sp4_partner.sv]
// Far-side serial device: async frame sender and sync data source
`timescale 1ns/1ps
module sp4_partner (
	// Clock
	input wire sys_clk,
	// Shift clock or data from the port
	input wire txd_q,
	// Line toward the port; pulled up when released
	output reg line_q = 1'b1
);
	reg txd_prev_q = 1'b1;
	reg m0_en_q = 1'b0;
	reg [7:0] m0_byte_q = 8'h00;
	reg [2:0] m0_idx_q = 3'h0;
	always @(posedge sys_clk)
	begin
		txd_prev_q <= txd_q;
		if (m0_en_q && txd_prev_q && !txd_q)
		begin
			line_q <= m0_byte_q[m0_idx_q];
			m0_idx_q <= m0_idx_q + 3'h1;
		end
	end
	task m0_arm(input [7:0] b, input en);
	begin
		@(posedge sys_clk);
		m0_byte_q <= b;
		m0_idx_q <= 3'h0;
		m0_en_q <= en;
		line_q <= 1'b1;
	end
	endtask
	// Frame bits go out LSB first, per clocks each
	task send(input [10:0] bits, input integer nb, input integer per);
		integer i;
	begin
		for (i = 0; i < nb; i = i + 1)
		begin
			@(posedge sys_clk);
			line_q <= bits[i];
			repeat (per - 1) @(posedge sys_clk);
		end
		@(posedge sys_clk);
		line_q <= 1'b1;
	end
	endtask
endmodule // sp4_partner

// [bench/sp4_serial_port_assertions.sv]
// Concurrent checks on the serial port pins and control image
`timescale 1ns/1ps
module sp4_checker (
	// Clock and reset
	input wire sys_clk,
	input wire reset,
	// Control access
	input wire serial_control_wr,
	input wire [7:0] serial_control_wdata,
	input wire [7:0] serial_control_rdata_q,
	input wire frame_err_select,
	// Data and pins
	input wire [7:0] serial_buffer_rdata_q,
	input wire txd_q,
	input wire rxd_out_q,
	input wire rxd_oe_q
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	// Low phase of the shift clock: 2 clocks fast, 6 clocks slow
	sequence sclk_low_s;
		!txd_q ##1 !txd_q ##1 (txd_q or (!txd_q [*4] ##1 txd_q));
	endsequence
	sclk_low_a: assert property (
		rxd_oe_q && $fell(txd_q) |-> sclk_low_s)
		else $error("shift clock low phase length");
	sclk_high_a: assert property (
		rxd_oe_q && $rose(txd_q) |-> txd_q [*2])
		else $error("shift clock high phase too short");
	sdata_hold_a: assert property (
		rxd_oe_q && !txd_q |-> $stable(rxd_out_q))
		else $error("sync data moved while clock low");
	tx_done_idle_a: assert property (
		$rose(serial_control_rdata_q[1]) && !$past(serial_control_wr, 2)
		|-> txd_q)
		else $error("transmit done raised before stop level");
	rx_hold_a: assert property (
		serial_control_rdata_q[0] && $past(serial_control_rdata_q[0])
		|-> $stable(serial_buffer_rdata_q))
		else $error("receive buffer changed while flag set");
	fe_sticky_a: assert property (
		frame_err_select && $past(frame_err_select)
		&& $past(frame_err_select, 2) && $past(frame_err_select, 3)
		&& $past(serial_control_rdata_q[7]) && !$past(serial_control_wr)
		&& !$past(serial_control_wr, 2) |-> serial_control_rdata_q[7])
		else $error("framing error cleared without write");
	rx_halt_a: assert property (
		!frame_err_select && !$past(frame_err_select)
		&& serial_control_rdata_q[7:6] == 2'h0
		&& serial_control_rdata_q[0] && $past(serial_control_rdata_q[0])
		&& !rxd_oe_q && !$past(rxd_oe_q) |-> $stable(txd_q))
		else $error("sync reception ran with flag set");
	ctl_write_a: assert property (
		$past(serial_control_wr, 2) && !frame_err_select
		&& !$past(frame_err_select) && !$past(frame_err_select, 2)
		|-> (serial_control_rdata_q & 8'hf8)
		== ($past(serial_control_wdata, 2) & 8'hf8))
		else $error("control bits not written through");
endmodule // sp4_checker

bind sp4_serial_port sp4_checker u_sp4_chk (
	.sys_clk(sys_clk),
	.reset(reset),
	.serial_control_wr(serial_control_wr),
	.serial_control_wdata(serial_control_wdata),
	.serial_control_rdata_q(serial_control_rdata_q),
	.frame_err_select(frame_err_select),
	.serial_buffer_rdata_q(serial_buffer_rdata_q),
	.txd_q(txd_q),
	.rxd_out_q(rxd_out_q),
	.rxd_oe_q(rxd_oe_q)
);

// [bench/tb_sp4_serial_port.sv]
// Self-checking bench for the four-mode serial port
`timescale 1ns/1ps
module tb_sp4_serial_port;
	reg sys_clk;
	reg reset = 1'b1;
	reg wr = 1'b0;
	reg [7:0] wdata = 8'h00;
	reg frame_err_select = 1'b0;
	reg baud_double = 1'b0;
	reg valid = 1'b0;
	reg [7:0] data = 8'h00;
	reg timer_ovf = 1'b0;
	wire [7:0] ctl_q;
	wire [7:0] rbuf_q;
	wire wr_ready;
	wire txd_q;
	wire rxd_out_q;
	wire rxd_oe_q;
	wire p_line;
	wire rxd_in;
	integer err_total = 0;
	integer cmp_count = 0;
	reg [10:0] fr;
	// The port owns the pin while its enable is high
	assign rxd_in = rxd_oe_q ? rxd_out_q : p_line;
	sp4_serial_port DUT (
		.sys_clk(sys_clk),
		.reset(reset),
		.serial_control_wr(wr),
		.serial_control_wdata(wdata),
		.serial_control_rdata_q(ctl_q),
		.frame_err_select(frame_err_select),
		.baud_double(baud_double),
		.serial_buffer_wr_valid(valid),
		.serial_buffer_wr_data(data),
		.serial_buffer_wr_ready(wr_ready),
		.serial_buffer_rdata_q(rbuf_q),
		.timer_ovf(timer_ovf),
		.txd_q(txd_q),
		.rxd_in(rxd_in),
		.rxd_out_q(rxd_out_q),
		.rxd_oe_q(rxd_oe_q)
	);
	sp4_partner u_far (.sys_clk(sys_clk), .txd_q(txd_q), .line_q(p_line));
	initial
	begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk)
		timer_ovf <= ~timer_ovf;
	task chk(input [31:0] seen, input [31:0] exp);
	begin
		cmp_count = cmp_count + 1;
		if (seen !== exp)
		begin
			err_total = err_total + 1;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	end
	endtask
	task end_of_test;
	begin
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	end
	endtask
	task tmo;
	begin
		err_total = err_total + 1;
		end_of_test;
	end
	endtask
	task wctl(input [7:0] v);
	begin
		@(posedge sys_clk);
		wr <= 1'b1;
		wdata <= v;
		@(posedge sys_clk);
		wr <= 1'b0;
		repeat (2) @(posedge sys_clk);
	end
	endtask
	task wait_ctl(input integer b, input integer n);
		integer j;
	begin
		for (j = 0; j < n && ctl_q[b] !== 1'b1; j = j + 1)
			@(negedge sys_clk);
		if (j >= n)
			tmo;
	end
	endtask
	task wait_txd(input v, input integer n);
		integer j;
	begin
		for (j = 0; j < n && txd_q !== v; j = j + 1)
			@(negedge sys_clk);
		if (j >= n)
			tmo;
	end
	endtask
	// Request held until an edge that sees ready; withdrawn after 8 tries
	task push(input [7:0] b, output ok);
		integer i;
	begin
		@(posedge sys_clk);
		valid <= 1'b1;
		data <= b;
		ok = 1'b0;
		for (i = 0; i < 8 && !ok; i = i + 1)
		begin
			@(negedge sys_clk);
			ok = wr_ready;
			@(posedge sys_clk);
		end
		valid <= 1'b0;
	end
	endtask
	task grab(input integer per);
		integer i;
	begin
		wait_txd(1'b0, 4000);
		repeat (per / 2) @(negedge sys_clk);
		for (i = 0; i < 11; i = i + 1)
		begin
			fr[i] = txd_q;
			if (i < 10)
				repeat (per) @(negedge sys_clk);
		end
	end
	endtask
	task g3(input integer k);
	begin
		grab(32);
		chk(fr, {2'h2, 8'h30 + k[7:0], 1'b0});
	end
	endtask
	task t_tx2;
		reg ok;
	begin
		wctl(8'h58);
		push(8'ha5, ok);
		grab(64);
		chk(fr, {2'h3, 8'ha5, 1'b0});
		wait_ctl(1, 40);
		chk(ctl_q[1], 1'b1);
	end
	endtask
	task t_fifo;
		reg ok;
		integer n;
		integer k;
	begin
		baud_double <= 1'b1;
		wctl(8'hc0);
		n = 0;
		ok = 1'b1;
		fork
			while (ok && n < 12)
			begin
				push(8'h30 + n[7:0], ok);
				n = n + ok;
			end
			for (k = 0; k < 8; k = k + 1)
				g3(k);
		join
		chk(n >= 8, 1'b1);
		for (k = 8; k < n; k = k + 1)
			g3(k);
	end
	endtask
	task t_rx1;
	begin
		wctl(8'h90);
		u_far.send({2'h3, 8'h3c, 1'b0}, 10, 32);
		wait_ctl(0, 100);
		chk({ctl_q[2], rbuf_q}, {1'b1, 8'h3c});
		u_far.send({2'h3, 8'h77, 1'b0}, 10, 32);
		repeat (20) @(posedge sys_clk);
		chk(rbuf_q, 8'h3c);
		wctl(8'h90);
		u_far.send(11'h7fe, 1, 2);
		repeat (60) @(posedge sys_clk);
		u_far.send({2'h3, 8'h5a, 1'b0}, 10, 32);
		wait_ctl(0, 100);
		chk(rbuf_q, 8'h5a);
	end
	endtask
	task t_fe;
	begin
		wctl(8'hd0);
		frame_err_select <= 1'b1;
		u_far.send({2'h1, 8'hc3, 1'b0}, 11, 32);
		wait_ctl(0, 100);
		chk({ctl_q[7], ctl_q[2], rbuf_q}, {2'h3, 8'hc3});
		frame_err_select <= 1'b0;
		wctl(8'hd0);
		frame_err_select <= 1'b1;
		u_far.send({2'h2, 8'h11, 1'b0}, 11, 32);
		wait_ctl(0, 100);
		chk({ctl_q[7], ctl_q[2], rbuf_q}, {2'h2, 8'h11});
		wctl(8'h50);
		chk(ctl_q[7], 1'b0);
		frame_err_select <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk(ctl_q[7:6], 2'h3);
	end
	endtask
	task t_m0tx(input [7:0] c, input [7:0] b, input integer per);
		reg ok;
		reg [7:0] d;
		integer i;
		time t0;
	begin
		wctl(c);
		push(b, ok);
		for (i = 0; i < 8; i = i + 1)
		begin
			wait_txd(1'b0, 200);
			wait_txd(1'b1, 200);
			d[i] = rxd_out_q;
			if (i == 1)
				chk($time - t0, per * 25);
			t0 = $time;
		end
		wait_ctl(1, 8);
		chk(d, b);
	end
	endtask
	task t_m0rx;
	begin
		u_far.m0_arm(8'h6b, 1'b1);
		wctl(8'h10);
		wait_ctl(0, 300);
		u_far.m0_arm(8'h00, 1'b0);
		chk(rbuf_q, 8'h6b);
		repeat (40) @(posedge sys_clk);
		chk(rbuf_q, 8'h6b);
	end
	endtask
	initial
	begin
		repeat (6) @(posedge sys_clk);
		reset <= 1'b0;
		repeat (2) @(posedge sys_clk);
		chk({txd_q, rxd_oe_q, rbuf_q, ctl_q}, 18'h20000);
		t_tx2;
		t_fifo;
		t_rx1;
		t_fe;
		t_m0tx(8'h00, 8'h96, 12);
		t_m0tx(8'h20, 8'h69, 4);
		t_m0rx;
		end_of_test;
	end
endmodule // tb_sp4_serial_port

// [verilog/sp4_baud.v]
// Oversampling tick generator: sixteen ticks per bit in the async modes
`timescale 1ns/1ps
`include "sp4_regs.vh"
module sp4_baud (
	// Clock and reset
	input wire sys_clk,
	input wire reset,
	// Rate selection
	input wire [1:0] mode,
	input wire baud_double,
	input wire timer_ovf,
	// Sixteen-times bit rate tick
	output reg tick16_q
);
	reg [1:0] cnt_q;
	reg [1:0] limit;
	reg event_in;

	always @*
	begin
		if (mode == `SP4_MODE_11OSC)
		begin
			event_in = 1'b1;
			limit = baud_double ? `SP4_OSC_DIV_FAST : `SP4_OSC_DIV_SLOW;
		end
		else
		begin
			event_in = timer_ovf;
			limit = baud_double ? `SP4_OVF_DIV_FAST : `SP4_OVF_DIV_SLOW;
		end
	end

	always @(posedge sys_clk)
	begin
		if (reset)
		begin
			cnt_q <= 2'h0;
			tick16_q <= 1'b0;
		end
		else
		begin
			tick16_q <= 1'b0;
			if (event_in)
			begin
				if (cnt_q >= limit)
				begin
					cnt_q <= 2'h0;
					tick16_q <= 1'b1;
				end
				else
					cnt_q <= cnt_q + 1'b1;
			end
		end
	end
endmodule // sp4_baud

// [verilog/sp4_fifo.v]
// Transmit FIFO between the serial buffer write port and the transmitter
`timescale 1ns/1ps
module sp4_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	// Clock and reset
	input wire sys_clk,
	input wire reset,
	// Fill side
	input wire in_valid,
	input wire [WIDTH-1:0] in_data,
	output reg in_ready_q,
	// Drain side
	output reg out_valid_q,
	output wire [WIDTH-1:0] out_data,
	input wire out_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_q;
	reg [AW-1:0] rd_ptr_q;
	reg [AW:0] count_q;
	reg [AW:0] count_d;
	wire push;
	wire pop;

	assign push = in_valid & in_ready_q;
	assign pop = out_ready & out_valid_q;
	assign out_data = mem[rd_ptr_q];

	always @*
	begin
		count_d = count_q;
		if (push & ~pop)
			count_d = count_q + 1'b1;
		else if (pop & ~push)
			count_d = count_q - 1'b1;
	end

	always @(posedge sys_clk)
	begin
		if (push)
			mem[wr_ptr_q] <= in_data;
		if (reset)
		begin
			wr_ptr_q <= {AW{1'b0}};
			rd_ptr_q <= {AW{1'b0}};
			count_q <= {(AW+1){1'b0}};
			in_ready_q <= 1'b0;
			out_valid_q <= 1'b0;
		end
		else
		begin
			if (push)
				wr_ptr_q <= wr_ptr_q + 1'b1;
			if (pop)
				rd_ptr_q <= rd_ptr_q + 1'b1;
			count_q <= count_d;
			// Flags registered from the next count so both stay honest
			in_ready_q <= (count_d != DEPTH[AW:0]);
			out_valid_q <= (count_d != {(AW+1){1'b0}});
		end
	end
endmodule // sp4_fifo

// [verilog/sp4_regs.vh]
// Constants of the four-mode serial port: control bit positions, resets, timing
`ifndef SP4_REGS_VH
`define SP4_REGS_VH

// Serial control register bit positions
`define SP4_CTL_MODE_B0_FE 7
`define SP4_CTL_MODE_B1 6
`define SP4_CTL_MULTIPROC 5
`define SP4_CTL_RX_EN 4
`define SP4_CTL_TX_NINTH 3
`define SP4_CTL_RX_NINTH 2
`define SP4_CTL_TX_DONE 1
`define SP4_CTL_RX_DONE 0
`define SP4_CTL_RESET 8'h00

// Mode codes, {mode_select_b1, mode_select_b0}
`define SP4_MODE_SYNC 2'h0
`define SP4_MODE_10BIT 2'h1
`define SP4_MODE_11OSC 2'h2
`define SP4_MODE_11TMR 2'h3

// Synchronous shift clock: last phase of the period, falling and rising phases, in clocks
`define SP4_M0_SLOW_LAST 4'hb
`define SP4_M0_SLOW_FALL 4'h3
`define SP4_M0_SLOW_RISE 4'h9
`define SP4_M0_FAST_LAST 4'h3
`define SP4_M0_FAST_FALL 4'h1
`define SP4_M0_FAST_RISE 4'h3

// Oversampling: rollover state and the three voting samples
`define SP4_DIV_LAST 4'hf
`define SP4_VOTE_S1 4'h7
`define SP4_VOTE_S2 4'h8
`define SP4_VOTE_S3 4'h9

// Oversample tick spacing, minus one: osc clocks (mode 2), overflows (1, 3)
`define SP4_OSC_DIV_FAST 2'h1
`define SP4_OSC_DIV_SLOW 2'h3
`define SP4_OVF_DIV_FAST 2'h0
`define SP4_OVF_DIV_SLOW 2'h1

// Frame lengths in bit times, and data bits of a synchronous frame
`define SP4_FRAME_10 4'ha
`define SP4_FRAME_11 4'hb
`define SP4_SYNC_BITS 4'h8

`endif

// [verilog/sp4_serial_port.v]
// Four-mode serial port: synchronous shift mode and three async modes
`timescale 1ns/1ps
`include "sp4_regs.vh"
module sp4_serial_port (
	// Clock and reset
	input wire sys_clk,
	input wire reset,
	// Serial control register access
	input wire serial_control_wr,
	input wire [7:0] serial_control_wdata,
	output reg [7:0] serial_control_rdata_q,
	// Power control bits
	input wire frame_err_select,
	input wire baud_double,
	// Serial buffer: transmit side through the FIFO, receive buffer read
	input wire serial_buffer_wr_valid,
	input wire [7:0] serial_buffer_wr_data,
	output wire serial_buffer_wr_ready,
	output reg [7:0] serial_buffer_rdata_q,
	// Timer overflow pulse for modes 1 and 3
	input wire timer_ovf,
	// Transmit pin: data in async modes, shift clock in sync mode
	output reg txd_q,
	// Receive pin, two-way in sync mode
	input wire rxd_in,
	output reg rxd_out_q,
	output reg rxd_oe_q
);
	reg mode_select_b0_q;
	reg mode_select_b1_q;
	reg multiproc_enable_q;
	reg rx_enable_q;
	reg tx_ninth_bit_q;
	reg rx_ninth_bit_q;
	reg tx_done_flag_q;
	reg rx_done_flag_q;
	reg framing_error_flag_q;
	// Transmit engine
	reg tx_busy_q;
	reg [10:0] tx_shift_q;
	reg [3:0] tx_left_q;
	reg [3:0] tx_div_q;
	// Synchronous mode engine
	reg m0_rx_q;
	reg [3:0] m0_ph_q;
	// Async receive engine
	reg rx_act_q;
	reg [3:0] rx_div_q;
	reg [3:0] rx_bit_q;
	reg [1:0] rx_smp_q;
	reg [7:0] rx_shift_q;
	reg rx_nin_q;
	reg rxd_prev_q;

	wire [1:0] mode;
	wire is_sync;
	wire eleven;
	wire tick16;
	wire fifo_valid;
	wire [7:0] fifo_data;
	wire tx_take;
	wire tx_roll;
	wire m0_run;
	wire [3:0] m0_last;
	wire [3:0] m0_fall;
	wire [3:0] m0_rise;
	wire vote;
	wire [3:0] rx_stop_idx;
	// Event pulses registered so every process sees them on the same edge
	reg ti_set_q;
	reg ri_set_q;
	reg fe_set_q;
	reg rx_load_q;

	assign mode = {mode_select_b1_q, mode_select_b0_q};
	assign is_sync = (mode == `SP4_MODE_SYNC);
	assign eleven = mode[1];
	// A new byte is taken only when both engines are quiet (half duplex sync)
	assign tx_take = fifo_valid & ~tx_busy_q & ~m0_rx_q;
	assign tx_roll = tick16 & (tx_div_q == `SP4_DIV_LAST);
	assign m0_run = is_sync & (tx_busy_q | m0_rx_q);
	assign m0_last = multiproc_enable_q ? `SP4_M0_FAST_LAST :
		`SP4_M0_SLOW_LAST;
	assign m0_fall = multiproc_enable_q ? `SP4_M0_FAST_FALL :
		`SP4_M0_SLOW_FALL;
	assign m0_rise = multiproc_enable_q ? `SP4_M0_FAST_RISE :
		`SP4_M0_SLOW_RISE;
	assign vote = (rx_smp_q[0] & rx_smp_q[1]) | (rx_smp_q[0] & rxd_in) |
		(rx_smp_q[1] & rxd_in);
	assign rx_stop_idx = eleven ? (`SP4_FRAME_11 - 4'h1) :
		(`SP4_FRAME_10 - 4'h1);

	sp4_baud u_baud (
		.sys_clk(sys_clk),
		.reset(reset),
		.mode(mode),
		.baud_double(baud_double),
		.timer_ovf(timer_ovf),
		.tick16_q(tick16)
	);

	// Back-pressure: writes stall while eight bytes wait for the line
	sp4_fifo #(
		.WIDTH(8),
		.DEPTH(8),
		.AW(3)
	) u_txfifo (
		.sys_clk(sys_clk),
		.reset(reset),
		.in_valid(serial_buffer_wr_valid),
		.in_data(serial_buffer_wr_data),
		.in_ready_q(serial_buffer_wr_ready),
		.out_valid_q(fifo_valid),
		.out_data(fifo_data),
		.out_ready(tx_take)
	);

	// Transmitter, both sync and async
	always @(posedge sys_clk)
	begin
		ti_set_q <= 1'b0;
		if (reset)
		begin
			tx_busy_q <= 1'b0;
			tx_shift_q <= 11'h7ff;
			tx_left_q <= 4'h0;
			tx_div_q <= 4'h0;
		end
		else
		begin
			if (tick16)
				tx_div_q <= tx_div_q + 1'b1;
			if (tx_take)
			begin
				tx_busy_q <= 1'b1;
				if (is_sync)
				begin
					tx_shift_q <= {3'h7, fifo_data};
					tx_left_q <= `SP4_SYNC_BITS;
				end
				else if (eleven)
				begin
					tx_shift_q <= {1'b1, tx_ninth_bit_q, fifo_data, 1'b0};
					tx_left_q <= `SP4_FRAME_11;
				end
				else
				begin
					tx_shift_q <= {2'h3, fifo_data, 1'b0};
					tx_left_q <= `SP4_FRAME_10;
				end
			end
			else if (tx_busy_q & is_sync)
			begin
				if (m0_ph_q == m0_rise)
				begin
					tx_shift_q <= {1'b1, tx_shift_q[10:1]};
					tx_left_q <= tx_left_q - 1'b1;
				end
				if (m0_ph_q == m0_last && tx_left_q == 4'h0)
				begin
					tx_busy_q <= 1'b0;
					ti_set_q <= 1'b1;
				end
			end
			else if (tx_busy_q & tx_roll)
			begin
				// Bits leave only on rollovers of the free-running divider
				tx_shift_q <= {1'b1, tx_shift_q[10:1]};
				tx_left_q <= tx_left_q - 1'b1;
				if (tx_left_q == 4'h1)
				begin
					tx_busy_q <= 1'b0;
					ti_set_q <= 1'b1;
				end
			end
		end
	end

	// Pins and the synchronous shift clock phase
	always @(posedge sys_clk)
	begin
		if (reset)
		begin
			m0_rx_q <= 1'b0;
			m0_ph_q <= 4'h0;
			txd_q <= 1'b1;
			rxd_out_q <= 1'b1;
			rxd_oe_q <= 1'b0;
		end
		else
		begin
			if (is_sync & ~m0_rx_q & ~tx_busy_q & ~fifo_valid &
				rx_enable_q & ~rx_done_flag_q)
			begin
				m0_rx_q <= 1'b1;
				m0_ph_q <= 4'h0;
			end
			else if (m0_run)
			begin
				m0_ph_q <= (m0_ph_q == m0_last) ? 4'h0 : m0_ph_q + 1'b1;
				if (m0_ph_q == m0_fall)
					txd_q <= 1'b0;
				else if (m0_ph_q == m0_rise)
					txd_q <= 1'b1;
				if (ri_set_q)
					m0_rx_q <= 1'b0;
			end
			else
			begin
				m0_ph_q <= 4'h0;
				// Async start bit waits for the divider rollover
				txd_q <= (is_sync | ~tx_busy_q) ? 1'b1 : txd_q;
			end
			if (!is_sync && tx_busy_q && tx_roll)
				txd_q <= tx_shift_q[0];
			// Data leads the falling shift clock edge by a quarter period
			rxd_oe_q <= is_sync & tx_busy_q;
			if (is_sync & tx_busy_q & (m0_ph_q == 4'h0))
				rxd_out_q <= tx_shift_q[0];
		end
	end

	// Receivers
	always @(posedge sys_clk)
	begin
		ri_set_q <= 1'b0;
		fe_set_q <= 1'b0;
		rx_load_q <= 1'b0;
		if (reset)
		begin
			rx_act_q <= 1'b0;
			rx_div_q <= 4'h0;
			rx_bit_q <= 4'h0;
			rx_smp_q <= 2'h3;
			rx_shift_q <= 8'h00;
			rx_nin_q <= 1'b0;
			rxd_prev_q <= 1'b1;
		end
		else if (is_sync)
		begin
			rx_act_q <= 1'b0;
			rxd_prev_q <= 1'b1;
			if (!m0_rx_q)
				rx_bit_q <= 4'h0;
			else if (m0_ph_q == m0_rise)
			begin
				rx_shift_q <= {rxd_in, rx_shift_q[7:1]};
				rx_bit_q <= rx_bit_q + 1'b1;
				if (rx_bit_q == `SP4_SYNC_BITS - 4'h1)
				begin
					ri_set_q <= 1'b1;
					rx_load_q <= 1'b1;
				end
			end
		end
		else if (tick16)
		begin
			rxd_prev_q <= rxd_in;
			if (!rx_act_q)
			begin
				if (rx_enable_q & rxd_prev_q & ~rxd_in)
				begin
					rx_act_q <= 1'b1;
					rx_div_q <= 4'h0;
					rx_bit_q <= 4'h0;
				end
			end
			else
			begin
				rx_div_q <= rx_div_q + 1'b1;
				if (rx_div_q == `SP4_VOTE_S1)
					rx_smp_q[0] <= rxd_in;
				if (rx_div_q == `SP4_VOTE_S2)
					rx_smp_q[1] <= rxd_in;
				if (rx_div_q == `SP4_VOTE_S3)
				begin
					rx_bit_q <= rx_bit_q + 1'b1;
					if (rx_bit_q == 4'h0)
					begin
						if (vote)
							rx_act_q <= 1'b0;
					end
					else if (rx_bit_q == rx_stop_idx)
					begin
						rx_act_q <= 1'b0;
						fe_set_q <= ~vote;
						if (!eleven)
							rx_nin_q <= vote;
						if (~rx_done_flag_q & (~multiproc_enable_q | vote))
						begin
							ri_set_q <= 1'b1;
							rx_load_q <= 1'b1;
						end
					end
					else if (rx_bit_q == `SP4_SYNC_BITS + 4'h1)
						rx_nin_q <= vote;
					else
						rx_shift_q <= {vote, rx_shift_q[7:1]};
				end
			end
		end
	end

	// Control flags; a hardware set wins over a software write
	always @(posedge sys_clk)
	begin
		if (reset)
		begin
			mode_select_b0_q <= 1'b0;
			mode_select_b1_q <= 1'b0;
			multiproc_enable_q <= 1'b0;
			rx_enable_q <= 1'b0;
			tx_ninth_bit_q <= 1'b0;
			rx_ninth_bit_q <= 1'b0;
			tx_done_flag_q <= 1'b0;
			rx_done_flag_q <= 1'b0;
			framing_error_flag_q <= 1'b0;
			serial_buffer_rdata_q <= 8'h00;
			serial_control_rdata_q <= `SP4_CTL_RESET;
		end
		else
		begin
			if (serial_control_wr)
			begin
				if (!frame_err_select)
					mode_select_b0_q <= serial_control_wdata[`SP4_CTL_MODE_B0_FE];
				mode_select_b1_q <= serial_control_wdata[`SP4_CTL_MODE_B1];
				multiproc_enable_q <= serial_control_wdata[`SP4_CTL_MULTIPROC];
				rx_enable_q <= serial_control_wdata[`SP4_CTL_RX_EN];
				tx_ninth_bit_q <= serial_control_wdata[`SP4_CTL_TX_NINTH];
			end
			if (rx_load_q)
			begin
				serial_buffer_rdata_q <= rx_shift_q;
				if (is_sync)
					rx_ninth_bit_q <= rx_ninth_bit_q;
				else
					rx_ninth_bit_q <= rx_nin_q;
			end
			else if (serial_control_wr)
				rx_ninth_bit_q <= serial_control_wdata[`SP4_CTL_RX_NINTH];
			tx_done_flag_q <= ti_set_q | (serial_control_wr ?
				serial_control_wdata[`SP4_CTL_TX_DONE] : tx_done_flag_q);
			rx_done_flag_q <= ri_set_q | (serial_control_wr ?
				serial_control_wdata[`SP4_CTL_RX_DONE] : rx_done_flag_q);
			// Software may only clear the error, and only through bit 7
			framing_error_flag_q <= fe_set_q | (framing_error_flag_q &
				~(serial_control_wr & frame_err_select &
				~serial_control_wdata[`SP4_CTL_MODE_B0_FE]));
			serial_control_rdata_q <= {
				frame_err_select ? framing_error_flag_q :
				mode_select_b0_q,
				mode_select_b1_q, multiproc_enable_q, rx_enable_q,
				tx_ninth_bit_q, rx_ninth_bit_q, tx_done_flag_q,
				rx_done_flag_q};
		end
	end
endmodule // sp4_serial_port
